/* File: hdl/cswc_pkg.sv */
// Notes on behaviour
// - System clock is oscillator divided by four.
// - Timing pin goes high, then stops, on standby.
// - Stop halts clock high and stops oscillator.
// - Stop cascades timers, loads FF/07, prescale sixteen.
// - External interrupt in run, or reset, releases the cascade.
// - Interrupt in stop restarts the oscillator.
// - Clock held high until timer 4 overflows.
// - Wait halts clock high, oscillator keeps running.
// - Interrupt ends wait with no settling delay.
// - Timer overflows every loaded value plus one.
package cswc_pkg;
  localparam int          DIV_W          = 2;
  localparam logic [1:0]  DIV_LAST       = 2'h3;
  localparam logic [1:0]  DIV_FIRST      = 2'h0;
  localparam int          DIV_HIGH_BIT   = 1;
  localparam int          PRE_W          = 4;
  localparam logic [3:0]  PRE_LAST       = 4'hF;
  localparam logic [3:0]  PRE_RESET      = 4'h0;
  localparam int          TMR_W          = 8;
  localparam logic [7:0]  T3_STOP_LOAD   = 8'hFF;
  localparam logic [7:0]  T4_STOP_LOAD   = 8'h07;
  localparam logic [7:0]  TMR_ZERO       = 8'h00;

  typedef enum logic [2:0] {
    CSWC_RUN,
    CSWC_STOP_PEND,
    CSWC_STOPPED,
    CSWC_SETTLE,
    CSWC_WAIT_PEND,
    CSWC_WAITING
  } cswc_state_t;
endpackage

/* File: hdl/cswc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module cswc_timer
  import cswc_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic [TMR_W-1:0] loadVal,
  input  wire logic             tick,
  output logic      [TMR_W-1:0] count,
  output logic                  overflow
);
  logic [TMR_W-1:0] count_r;
  logic [TMR_W-1:0] reload_r;
  logic [TMR_W-1:0] count_nxt;

  // Underflow past zero reloads, so the period is loaded value plus one
  assign overflow  = tick && !load && (count_r == TMR_ZERO);
  assign count_nxt = load     ? loadVal :
                     overflow ? reload_r :
                     tick     ? count_r - 8'h01 : count_r;
  assign count     = count_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      count_r  <= TMR_ZERO;
      reload_r <= TMR_ZERO;
    end else begin
      count_r <= count_nxt;
      if (load) begin
        reload_r <= loadVal;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/cswc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cswc_top
  import cswc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic stopInstruction,
  input  wire logic waitInstruction,
  input  wire logic intAccept,
  input  wire logic extIntAccept,
  output logic      sysClkOut_r,
  output logic      mainOscRun_r,
  output logic      timerCascade_r,
  output logic      t3ForcedPrescale_r,
  output logic      stopped_r,
  output logic      waiting_r
);
  cswc_state_t      state_r;
  cswc_state_t      state_nxt;
  logic [DIV_W-1:0] divCnt_r;
  logic [PRE_W-1:0] preCnt_r;
  logic             t3Ovf;
  logic             t4Ovf;
  logic [PRE_W-1:0] preCnt_nxt;
  logic             mainOscRun_nxt;
  logic             stopped_nxt;
  logic             waiting_nxt;
  logic             cascadeSet;
  logic             cascadeClear;
  logic             cascade_nxt;

  // Halted states keep the divider parked and the pin high
  function automatic logic cswc_is_held(input cswc_state_t s);
    case (s)
      CSWC_STOPPED: return 1'b1;
      CSWC_SETTLE:  return 1'b1;
      CSWC_WAITING: return 1'b1;
      default:      return 1'b0;
    endcase
  endfunction

  // Stop side covers the oscillator-off state and the settling after it
  function automatic logic cswc_is_stop_side(input cswc_state_t s);
    case (s)
      CSWC_STOPPED: return 1'b1;
      CSWC_SETTLE:  return 1'b1;
      default:      return 1'b0;
    endcase
  endfunction

  // Only the stopped state turns the oscillator off
  function automatic logic cswc_is_osc_off(input cswc_state_t s);
    return (s == CSWC_STOPPED);
  endfunction

  // Divider advances while running and parks at its first count while held
  function automatic logic [DIV_W-1:0] cswc_div_step(input logic held, input logic [DIV_W-1:0] d);
    if (held) begin
      return DIV_FIRST;
    end
    return d + 2'h1;
  endfunction

  // Pin is high in the first half of each divided period and while held
  function automatic logic cswc_pin_level(input logic held, input logic [DIV_W-1:0] d);
    if (held) begin
      return 1'b1;
    end
    return !d[DIV_HIGH_BIT];
  endfunction

  wire haltPhase   = (divCnt_r == DIV_LAST);
  wire clkHeld     = cswc_is_held(state_r);
  wire stopLoad    = (state_r == CSWC_STOP_PEND) && haltPhase;
  wire settling    = (state_r == CSWC_SETTLE);
  wire preTick     = settling && (preCnt_r == PRE_LAST);
  wire t4Tick      = settling && t3Ovf;
  wire [DIV_W-1:0] divCnt_nxt = cswc_div_step(clkHeld, divCnt_r);
  wire sysClk_nxt  = cswc_pin_level(clkHeld, divCnt_nxt);

  // The top level drives the FF/07 loads into both timers at the stop instant
  cswc_timer u_t3 (
    .mclk     (mclk),
    .reset    (reset),
    .load     (stopLoad),
    .loadVal  (T3_STOP_LOAD),
    .tick     (preTick),
    .count    (),
    .overflow (t3Ovf)
  );

  cswc_timer u_t4 (
    .mclk     (mclk),
    .reset    (reset),
    .load     (stopLoad),
    .loadVal  (T4_STOP_LOAD),
    .tick     (t4Tick),
    .count    (),
    .overflow (t4Ovf)
  );

  // Standby requests wait for the end of a low phase so the pin parks high
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CSWC_RUN: begin
        if (stopInstruction) begin
          state_nxt = CSWC_STOP_PEND;
        end else if (waitInstruction) begin
          state_nxt = CSWC_WAIT_PEND;
        end
      end
      CSWC_STOP_PEND: begin
        if (haltPhase) begin
          state_nxt = CSWC_STOPPED;
        end
      end
      CSWC_STOPPED: begin
        if (intAccept) begin
          state_nxt = CSWC_SETTLE;
        end
      end
      CSWC_SETTLE: begin
        if (t4Ovf) begin
          state_nxt = CSWC_RUN;
        end
      end
      CSWC_WAIT_PEND: begin
        if (haltPhase) begin
          state_nxt = CSWC_WAITING;
        end
      end
      CSWC_WAITING: begin
        if (intAccept) begin
          state_nxt = CSWC_RUN;
        end
      end
      default: begin
        state_nxt = CSWC_RUN;
      end
    endcase
  end

  // Cascade holds after wake-up until an external interrupt is taken in run
  assign preCnt_nxt     = settling ? preCnt_r + 4'h1 : PRE_RESET;
  assign mainOscRun_nxt = !cswc_is_osc_off(state_nxt);
  assign stopped_nxt    = cswc_is_stop_side(state_nxt);
  assign waiting_nxt    = (state_nxt == CSWC_WAITING);
  assign cascadeSet     = stopLoad;
  assign cascadeClear   = extIntAccept && (state_r == CSWC_RUN);
  // Set wins over a clear in the same cycle
  assign cascade_nxt    = cascadeSet ? 1'b1 : (cascadeClear ? 1'b0 : timerCascade_r);

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= CSWC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      divCnt_r <= DIV_FIRST;
    end else begin
      divCnt_r <= divCnt_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      preCnt_r <= PRE_RESET;
    end else begin
      preCnt_r <= preCnt_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sysClkOut_r <= 1'b1;
    end else begin
      sysClkOut_r <= sysClk_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mainOscRun_r <= 1'b1;
    end else begin
      mainOscRun_r <= mainOscRun_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stopped_r <= 1'b0;
    end else begin
      stopped_r <= stopped_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      waiting_r <= 1'b0;
    end else begin
      waiting_r <= waiting_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      timerCascade_r <= 1'b0;
    end else begin
      timerCascade_r <= cascade_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      t3ForcedPrescale_r <= 1'b0;
    end else begin
      t3ForcedPrescale_r <= cascade_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: dv/cswc_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cswc_asserts (
  input wire logic mclk,
  input wire logic reset,
  input wire logic intAccept,
  input wire logic sysClkOut_r,
  input wire logic mainOscRun_r,
  input wire logic timerCascade_r,
  input wire logic t3ForcedPrescale_r,
  input wire logic stopped_r,
  input wire logic waiting_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_osc_stop: assert property (!mainOscRun_r |-> stopped_r) else $error("osc off");
  a_halt_high: assert property (stopped_r || waiting_r |-> sysClkOut_r) else $error("halt low");
  a_wait_osc: assert property (waiting_r |-> mainOscRun_r) else $error("wait osc");
  a_casc_pair: assert property (timerCascade_r == t3ForcedPrescale_r) else $error("pair");
  a_stop_casc: assert property ($rose(stopped_r) |-> timerCascade_r) else $error("casc");
  a_wake_osc: assert property (stopped_r && intAccept |=> mainOscRun_r) else $error("wake");
  a_wait_wake: assert property (waiting_r && intAccept |=> !waiting_r) else $error("wait");
  a_low_phase: assert property ($fell(sysClkOut_r) |=> !sysClkOut_r ##1 sysClkOut_r) else $error("low");
  a_high_phase: assert property ($rose(sysClkOut_r) |=> sysClkOut_r ##1
    (!sysClkOut_r || stopped_r || waiting_r)) else $error("high");
endmodule
`default_nettype wire

/* File: dv/cswc_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cswc_top_tb_top;
  import cswc_pkg::*;
  logic       mclk = 1'b0, reset = 1'b1;
  logic [3:0] req = 4'h0;
  wire        stopInstruction = req[0], waitInstruction = req[1], intAccept = req[2], extIntAccept = req[3];
  logic       sysClkOut_r, mainOscRun_r, timerCascade_r, t3ForcedPrescale_r, stopped_r, waiting_r;
  int         n_mismatch = 0, compares = 0, n;
  time        t0;
  always #4 mclk = ~mclk;
  cswc_top i_cswc_top (.mclk, .reset, .stopInstruction, .waitInstruction, .intAccept, .extIntAccept,
    .sysClkOut_r, .mainOscRun_r, .timerCascade_r, .t3ForcedPrescale_r, .stopped_r, .waiting_r);
  function automatic int settleExp();
    return (int'(T4_STOP_LOAD) + 1) * (int'(T3_STOP_LOAD) + 1) * (int'(PRE_LAST) + 1);
  endfunction
  task automatic check(input bit ok, input string m);
    compares++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic pulse(input int i);
    @(posedge mclk);
    req[i] <= 1'b1;
    @(posedge mclk);
    req[i] <= 1'b0;
  endtask
  // Counts cycles until stopped_r (i=0) or waiting_r (i=1) reaches v
  task automatic waitSt(input int i, input logic v);
    n = 0;
    while ((i ? waiting_r : stopped_r) !== v && n < 40000) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(70));
    cyc(6);
    reset <= 1'b0;
    @(posedge sysClkOut_r);
    t0 = $time;
    @(posedge sysClkOut_r);
    check($time - t0 == (int'(DIV_LAST) + 1) * 8, "period");
    pulse(2);
    #1 check(stopped_r === 1'b0 && waiting_r === 1'b0, "int in run");
    for (int k = 0; k < 3; k++) begin
      cyc($urandom_range(1, 7));
      pulse(1);
      waitSt(1, 1'b1);
      check(n < 8 && sysClkOut_r === 1'b1 && mainOscRun_r === 1'b1, "wait entry");
      cyc($urandom_range(0, 20));
      pulse(2);
      #1 check(waiting_r === 1'b0, "wait exit");
    end
    pulse(0);
    waitSt(0, 1'b1);
    check(n < 8 && mainOscRun_r === 1'b0 && t3ForcedPrescale_r === 1'b1, "stop entry");
    cyc($urandom_range(1, 30));
    pulse(2);
    #1 check(mainOscRun_r === 1'b1 && sysClkOut_r === 1'b1, "osc restart");
    waitSt(0, 1'b0);
    check(n > settleExp() - 32 && n < settleExp() + 32, "settle length");
    pulse(3);
    #1 check(timerCascade_r === 1'b0, "ext release");
    @(posedge mclk);
    req <= 4'h3;
    @(posedge mclk);
    req <= 4'h0;
    waitSt(0, 1'b1);
    check(n < 8 && waiting_r === 1'b0 && timerCascade_r === 1'b1, "stop wins");
    pulse(2);
    pulse(3);
    #1 check(timerCascade_r === 1'b1 && stopped_r === 1'b1, "cascade in settle");
    cyc($urandom_range(10, 200));
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    #1 check(timerCascade_r === 1'b0 && t3ForcedPrescale_r === 1'b0 && stopped_r === 1'b0 &&
      mainOscRun_r === 1'b1, "reset release");
    final_report();
  end
  initial begin
    cyc(60000);
    n_mismatch++;
    final_report();
  end
endmodule
bind cswc_top cswc_asserts i_cswc_asserts (.mclk, .reset, .intAccept, .sysClkOut_r, .mainOscRun_r,
  .timerCascade_r, .t3ForcedPrescale_r, .stopped_r, .waiting_r);
`default_nettype wire
